//--- core/pdt_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef PDT_REGS_SVH
`define PDT_REGS_SVH
`define PDT_A_BMCTL 16'h0000
`define PDT_A_ISR1 16'h0012
`define PDT_A_ISR2 16'h0013
`define PDT_A_STCTL 16'h0016
`define PDT_A_STCS1 16'h001b
`define PDT_A_STCS2 16'h001c
`define PDT_A_CRCTL 16'h001e
`define PDT_A_CRRES 16'h016b
`define PDT_A_CRLOC1 16'h0180
`define PDT_A_CRPEAK 16'h018a
`define PDT_A_NOISE 16'h0197
`define PDT_A_LQI 16'h0198
`define PDT_A_DISCH 16'h0448
`define PDT_A_MCFG1 16'h0480
`define PDT_A_MCFG2 16'h0481
`define PDT_A_MTEMP 16'h0484
`define PDT_A_MSUP 16'h0485
`define PDT_BMC_LOOP 14
`define PDT_ISR1_ESD 11
`define PDT_ISR2_UV 0
`define PDT_ISR2_OT 1
`define PDT_CR_START 15
`define PDT_STC_CONT 14
`define PDT_STC_EN 13
`define PDT_STC_LOCK 10
`define PDT_STC_SYNC 9
`define PDT_ST1_RDERR 15
`define PDT_MC2_PER 1
`define PDT_MC2_ONE 0
`define PDT_LB_PCS 5'h01
`define PDT_LB_ANA 5'h02
`define PDT_LB_REV 5'h04
`define PDT_RST_MCFG1 16'h0001
`define PDT_RST_MCFG2 16'h0002
`define PDT_RST_STCS1 16'h000c
`define PDT_RST_STCS2 16'h0040
`define PDT_LQ_POOR 8'd40
`define PDT_LQ_GOOD 8'd70
`define PDT_LOCK_MATCHES 3'd4
`define PDT_CLK_NS 40
`define PDT_TDR_LISTEN_NS 2000
`define PDT_MON_TICK_NS 1000000
`define PDT_MON_MS_0 8'd16
`define PDT_MON_MS_1 8'd31
`define PDT_MON_MS_2 8'd48
`define PDT_MON_MS_3 8'd64
`define PDT_MON_MS_4 8'd96
`define PDT_MON_MS_5 8'd128
`define PDT_MON_MS_6 8'd192
`define PDT_MON_MS_7 8'd240
`endif

//--- core/pdt_pkg.sv
// Types shared by the diagnostic block
`default_nettype none
package pdt_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pdt_req_s;
  typedef struct packed {
    logic valid;
    logic is_open;
    logic [9:0] time_cnt;
    logic [7:0] amp;
  } pdt_refl_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pdt_byte_s;
  typedef struct packed {
    logic mii;
    logic pcs;
    logic analog;
    logic reverse;
    logic rx_pma_iso;
    logic mac_tx_iso;
  } pdt_loop_s;
  typedef enum logic [1:0] {CR_IDLE, CR_PULSE, CR_LISTEN} pdt_cr_e;
  typedef enum logic [1:0] {TX_IDLE, TX_PKT, TX_GAP} pdt_tx_e;
endpackage
`default_nettype wire

//--- core/pdt_diag.sv
// Diagnostic tool kit: link quality, discharge log, reflectometry, monitors
// How it works
// - Link quality class: 00 no link, 01 poor, 10 good, 11 excellent.
// - Low byte holds quality value; poor <=40, good <=70, excellent above.
// - Quality value follows each noise-ratio measurement while active.
// - Noise-ratio register low byte holds ratio in tenths of a decibel.
// - Discharge events counted separately for MAC-side and line-side pins.
// - Any logged discharge event sets bit 11 of interrupt status one.
// - Discharge status survives hardware and software resets.
// - Bit 15 starts reflectometry; bits 1:0 report its status.
// - Run results, second fault location and peak kinds kept in registers.
// - A run sends a pulse and records time and amplitude of reflections.
// - Temperature and supply monitors run by default and set status flags.
// - Three-bit period field, default 31 ms, range 16 to 240 ms.
// - Clear periodic bit, then set trigger bit for a single monitor run.
// - Temperature results and supply results in two monitor status registers.
// - Packet length is eleven bits in control two, gap eight bits in one.
// - Generator sends framed 15-bit pseudo-random data; checker compares it.
// - Erroneous byte count reads in bits 15:8 of control and status one.
// - Checker lock and sync status read from self-test control.
// - Continuous mode lets the error counter wrap to zero.
// - Writing bit 15 latches the error count and clears the counter.
// - Basic control bit 14 loops MAC data back and hides link.
// - Loop select 0001 loops inside the PCS and isolates receive PMA.
// - Generator and checker work with any loopback or a far-end loop.
// - Loop select 0010 selects analog echo loopback.
// - Loop select 0100 selects reverse loopback, MAC transmit isolated.
`timescale 1ns/1ns
`default_nettype none
`include "pdt_regs.svh"
module pdt_diag import pdt_pkg::*; #(
  parameter int unsigned MON_TICK_CYCLES = `PDT_MON_TICK_NS / `PDT_CLK_NS
) (
  // Clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic por_rst,
  // Management register port
  input wire pdt_req_s reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Receiver measurements
  input wire logic link_up,
  input wire logic snr_valid,
  input wire logic [7:0] snr_meas,
  // Discharge sensors
  input wire logic esd_mii_evt,
  input wire logic esd_mdi_evt,
  // Reflectometry front end
  output logic cr_pulse,
  input wire pdt_refl_s refl,
  // Temperature and supply sensors
  output logic mon_sample,
  input wire logic [7:0] temp_code,
  input wire logic [7:0] analog_supply_code,
  input wire logic [7:0] io_supply_code,
  input wire logic over_temp,
  input wire logic under_volt,
  // Self-test data path
  output pdt_byte_s st_tx,
  input wire pdt_byte_s st_rx,
  // Loopback steering
  output pdt_loop_s loop_ctl,
  output logic link_ind
);
  localparam int unsigned CR_LISTEN_CYC = `PDT_TDR_LISTEN_NS / `PDT_CLK_NS;

  logic [15:0] bmctl_ff, isr1_ff, isr2_ff, stctl_ff, stcs1_ff, stcs2_ff;
  logic [15:0] mcfg1_ff, mcfg2_ff, mtemp_ff, msup_ff, disch_ff;
  logic [15:0] crres_ff, crloc1_ff, crpeak_ff;
  logic [7:0] noise_ff, lq_val_ff, err_cnt_ff, err_hold_ff;
  logic [1:0] lq_cls_ff, cr_stat_ff, cr_peaks_ff;
  logic [15:0] nxt_rdata;
  logic wr_bmctl, wr_stctl, wr_stcs1, wr_crctl, wr_mcfg2, mon_go;
  logic st_en, cont_mode, err_hit, rderr_req;
  pdt_cr_e cr_state_ff;
  logic [$clog2(CR_LISTEN_CYC+1)-1:0] cr_cnt_ff;
  logic [$clog2(MON_TICK_CYCLES+1)-1:0] tick_cnt_ff;
  logic [7:0] ms_cnt_ff;
  pdt_tx_e tx_state_ff;
  logic [10:0] tx_cnt_ff;
  logic [14:0] gen_ff, gen_adv, chk_ff, chk_adv;
  logic [2:0] match_ff;
  logic [1:0] fill_ff;
  logic lock_ff;

  // Eight steps of x^15 + x^14 + 1; newest bit enters at the bottom
  function automatic logic [14:0] prbs_adv8(input logic [14:0] s);
    logic [14:0] t;
    t = s;
    for (int i = 0; i < 8; i++) begin
      t = {t[13:0], t[14] ^ t[13]};
    end
    return t;
  endfunction

  // Monitor period lookup in milliseconds
  function automatic logic [7:0] mon_ms(input logic [2:0] code);
    case (code)
      3'h0: mon_ms = `PDT_MON_MS_0;
      3'h1: mon_ms = `PDT_MON_MS_1;
      3'h2: mon_ms = `PDT_MON_MS_2;
      3'h3: mon_ms = `PDT_MON_MS_3;
      3'h4: mon_ms = `PDT_MON_MS_4;
      3'h5: mon_ms = `PDT_MON_MS_5;
      3'h6: mon_ms = `PDT_MON_MS_6;
      default: mon_ms = `PDT_MON_MS_7;
    endcase
  endfunction

  // Write decode
  assign wr_bmctl = reg_req.wr && reg_req.addr == `PDT_A_BMCTL;
  assign wr_stctl = reg_req.wr && reg_req.addr == `PDT_A_STCTL;
  assign wr_stcs1 = reg_req.wr && reg_req.addr == `PDT_A_STCS1;
  assign wr_crctl = reg_req.wr && reg_req.addr == `PDT_A_CRCTL;
  assign wr_mcfg2 = reg_req.wr && reg_req.addr == `PDT_A_MCFG2;
  assign st_en = stctl_ff[`PDT_STC_EN];
  assign cont_mode = stctl_ff[`PDT_STC_CONT];
  assign rderr_req = wr_stcs1 && reg_req.wdata[`PDT_ST1_RDERR];

  // Plain control registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bmctl_ff <= 16'h0000;
      stctl_ff <= 16'h0000;
      stcs1_ff <= `PDT_RST_STCS1;
      stcs2_ff <= `PDT_RST_STCS2;
      mcfg1_ff <= `PDT_RST_MCFG1;
    end else if (reg_req.wr) begin
      if (wr_bmctl) bmctl_ff <= reg_req.wdata;
      if (wr_stctl) stctl_ff <= reg_req.wdata;
      if (wr_stcs1) stcs1_ff <= {8'h00, reg_req.wdata[7:0]};
      if (reg_req.addr == `PDT_A_STCS2) begin
        stcs2_ff <= {5'h00, reg_req.wdata[10:0]};
      end
      if (reg_req.addr == `PDT_A_MCFG1) begin
        mcfg1_ff <= {13'h0000, reg_req.wdata[2:0]};
      end
    end
  end

  // Loopback steering; MAC loop also hides link
  always_comb begin
    loop_ctl.mii = bmctl_ff[`PDT_BMC_LOOP];
    loop_ctl.pcs = stctl_ff[6:2] == `PDT_LB_PCS;
    loop_ctl.analog = stctl_ff[6:2] == `PDT_LB_ANA;
    loop_ctl.reverse = stctl_ff[6:2] == `PDT_LB_REV;
    loop_ctl.rx_pma_iso = loop_ctl.pcs;
    loop_ctl.mac_tx_iso = loop_ctl.reverse;
  end
  assign link_ind = link_up && !bmctl_ff[`PDT_BMC_LOOP];

  // Quality class and noise ratio track every fresh measurement
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      noise_ff <= 8'h00;
      lq_val_ff <= 8'h00;
      lq_cls_ff <= 2'h0;
    end else begin
      if (snr_valid) begin
        noise_ff <= snr_meas;
        lq_val_ff <= snr_meas;
      end
      if (!link_up) lq_cls_ff <= 2'h0;
      else if (lq_val_ff <= `PDT_LQ_POOR) lq_cls_ff <= 2'h1;
      else if (lq_val_ff <= `PDT_LQ_GOOD) lq_cls_ff <= 2'h2;
      else lq_cls_ff <= 2'h3;
    end
  end

  // Discharge log: only power-on clears it, system reset leaves it alone
  always_ff @(posedge clk) begin
    if (por_rst) begin
      disch_ff <= 16'h0000;
    end else begin
      if (esd_mii_evt && disch_ff[7:0] != 8'hff) begin
        disch_ff[7:0] <= disch_ff[7:0] + 8'h01;
      end
      if (esd_mdi_evt && disch_ff[15:8] != 8'hff) begin
        disch_ff[15:8] <= disch_ff[15:8] + 8'h01;
      end
    end
  end

  // Interrupt flags clear on read; a new event in that cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      isr1_ff <= 16'h0000;
      isr2_ff <= 16'h0000;
    end else begin
      if (reg_req.rd && reg_req.addr == `PDT_A_ISR1) isr1_ff <= 16'h0000;
      if (reg_req.rd && reg_req.addr == `PDT_A_ISR2) isr2_ff <= 16'h0000;
      if (esd_mii_evt || esd_mdi_evt) isr1_ff[`PDT_ISR1_ESD] <= 1'b1;
      if (mon_go && over_temp) isr2_ff[`PDT_ISR2_OT] <= 1'b1;
      if (mon_go && under_volt) isr2_ff[`PDT_ISR2_UV] <= 1'b1;
    end
  end

  // Reflectometry run: one pulse, then a fixed listening window
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cr_state_ff <= CR_IDLE;
      cr_cnt_ff <= '0;
      cr_stat_ff <= 2'h0;
      cr_peaks_ff <= 2'h0;
      crres_ff <= 16'h0000;
      crloc1_ff <= 16'h0000;
      crpeak_ff <= 16'h0000;
    end else begin
      case (cr_state_ff)
        CR_IDLE: begin
          if (wr_crctl && reg_req.wdata[`PDT_CR_START]) begin
            cr_state_ff <= CR_PULSE;
            cr_stat_ff <= 2'h1;
            cr_peaks_ff <= 2'h0;
            crpeak_ff <= 16'h0000;
          end
        end
        CR_PULSE: begin
          cr_state_ff <= CR_LISTEN;
          cr_cnt_ff <= '0;
        end
        CR_LISTEN: begin
          cr_cnt_ff <= cr_cnt_ff + 1'b1;
          if (refl.valid && cr_peaks_ff == 2'h0) begin
            crres_ff <= {refl.is_open, refl.amp[4:0], refl.time_cnt};
            crpeak_ff[0] <= refl.is_open;
            cr_peaks_ff <= 2'h1;
          end else if (refl.valid && cr_peaks_ff == 2'h1) begin
            crloc1_ff <= {refl.is_open, refl.amp[4:0], refl.time_cnt};
            crpeak_ff[1] <= refl.is_open;
            cr_peaks_ff <= 2'h2;
          end
          if (cr_cnt_ff == CR_LISTEN_CYC[$bits(cr_cnt_ff)-1:0] - 1'b1) begin
            cr_state_ff <= CR_IDLE;
            cr_stat_ff <= (cr_peaks_ff != 2'h0) ? 2'h3 : 2'h2;
          end
        end
        default: cr_state_ff <= CR_IDLE;
      endcase
    end
  end
  assign cr_pulse = cr_state_ff == CR_PULSE;

  // Monitor timing: millisecond ticks against the selected period
  assign mon_go = (mcfg2_ff[`PDT_MC2_PER] && tick_cnt_ff == '0
                   && ms_cnt_ff >= mon_ms(mcfg1_ff[2:0]) - 8'h01)
                  || mcfg2_ff[`PDT_MC2_ONE];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_ff <= '0;
      ms_cnt_ff <= 8'h00;
    end else if (mon_go) begin
      // Reload at once so one period spans exactly its milliseconds
      tick_cnt_ff <= MON_TICK_CYCLES[$bits(tick_cnt_ff)-1:0] - 1'b1;
      ms_cnt_ff <= 8'h00;
    end else if (tick_cnt_ff == '0) begin
      tick_cnt_ff <= MON_TICK_CYCLES[$bits(tick_cnt_ff)-1:0] - 1'b1;
      ms_cnt_ff <= ms_cnt_ff + 8'h01;
    end else begin
      tick_cnt_ff <= tick_cnt_ff - 1'b1;
    end
  end

  // Single run only fires once periodic mode is off; trigger self-clears
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mcfg2_ff <= `PDT_RST_MCFG2;
      mon_sample <= 1'b0;
      mtemp_ff <= 16'h0000;
      msup_ff <= 16'h0000;
    end else begin
      mon_sample <= mon_go;
      mcfg2_ff[`PDT_MC2_ONE] <= 1'b0;
      if (wr_mcfg2) begin
        mcfg2_ff[`PDT_MC2_PER] <= reg_req.wdata[`PDT_MC2_PER];
        mcfg2_ff[`PDT_MC2_ONE] <= reg_req.wdata[`PDT_MC2_ONE]
                                  && !mcfg2_ff[`PDT_MC2_PER];
      end
      if (mon_go) begin
        mtemp_ff <= {7'h00, over_temp, temp_code};
        msup_ff <= {io_supply_code, analog_supply_code};
      end
    end
  end

  // Next generator state, shared by the state and data flops
  assign gen_adv = prbs_adv8(gen_ff);
  // Generator: packets of set length, then the set gap, on repeat
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state_ff <= TX_IDLE;
      tx_cnt_ff <= 11'h000;
      gen_ff <= 15'h7fff;
      st_tx <= '0;
    end else begin
      st_tx.valid <= 1'b0;
      case (tx_state_ff)
        TX_IDLE: begin
          if (st_en) begin
            tx_state_ff <= TX_PKT;
            tx_cnt_ff <= 11'h000;
          end
        end
        TX_PKT: begin
          gen_ff <= gen_adv;
          st_tx.valid <= 1'b1;
          st_tx.data <= gen_adv[7:0];
          tx_cnt_ff <= tx_cnt_ff + 11'h001;
          if (tx_cnt_ff + 11'h001 >= stcs2_ff[10:0]) begin
            tx_state_ff <= TX_GAP;
            tx_cnt_ff <= 11'h000;
          end
        end
        TX_GAP: begin
          tx_cnt_ff <= tx_cnt_ff + 11'h001;
          if (tx_cnt_ff + 11'h001 >= {3'h0, stcs1_ff[7:0]}) begin
            tx_state_ff <= TX_PKT;
            tx_cnt_ff <= 11'h000;
          end
        end
        default: tx_state_ff <= TX_IDLE;
      endcase
      if (!st_en) tx_state_ff <= TX_IDLE;
    end
  end

  // Checker seeds itself from received bytes, so any loop path works
  assign chk_adv = prbs_adv8(chk_ff);
  assign err_hit = lock_ff && st_rx.valid && st_rx.data != chk_adv[7:0];
  always_ff @(posedge clk) begin
    if (sys_rst || !st_en) begin
      chk_ff <= 15'h0000;
      fill_ff <= 2'h0;
      match_ff <= 3'h0;
      lock_ff <= 1'b0;
    end else if (st_rx.valid) begin
      if (lock_ff) begin
        chk_ff <= chk_adv;
      end else begin
        chk_ff <= {chk_ff[6:0], st_rx.data};
        if (fill_ff != 2'h2) fill_ff <= fill_ff + 2'h1;
        if (fill_ff == 2'h2 && st_rx.data == chk_adv[7:0]) begin
          match_ff <= match_ff + 3'h1;
          if (match_ff + 3'h1 == `PDT_LOCK_MATCHES) lock_ff <= 1'b1;
        end else begin
          match_ff <= 3'h0;
        end
      end
    end
  end

  // Error counter saturates, or wraps in continuous mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_cnt_ff <= 8'h00;
      err_hold_ff <= 8'h00;
    end else if (rderr_req) begin
      err_hold_ff <= err_cnt_ff;
      err_cnt_ff <= err_hit ? 8'h01 : 8'h00;
    end else if (err_hit && (err_cnt_ff != 8'hff || cont_mode)) begin
      err_cnt_ff <= err_cnt_ff + 8'h01;
    end
  end

  // Read mux, answered one cycle after the request
  always_comb begin
    case (reg_req.addr)
      `PDT_A_BMCTL: nxt_rdata = bmctl_ff;
      `PDT_A_ISR1: nxt_rdata = isr1_ff;
      `PDT_A_ISR2: nxt_rdata = isr2_ff;
      `PDT_A_STCTL: nxt_rdata = {stctl_ff[15:11], lock_ff, fill_ff == 2'h2,
                                 stctl_ff[8:0]};
      `PDT_A_STCS1: nxt_rdata = {err_hold_ff, stcs1_ff[7:0]};
      `PDT_A_STCS2: nxt_rdata = stcs2_ff;
      `PDT_A_CRCTL: nxt_rdata = {14'h0000, cr_stat_ff};
      `PDT_A_CRRES: nxt_rdata = crres_ff;
      `PDT_A_CRLOC1: nxt_rdata = crloc1_ff;
      `PDT_A_CRPEAK: nxt_rdata = crpeak_ff;
      `PDT_A_NOISE: nxt_rdata = {8'h00, noise_ff};
      `PDT_A_LQI: nxt_rdata = {6'h00, lq_cls_ff, lq_val_ff};
      `PDT_A_DISCH: nxt_rdata = disch_ff;
      `PDT_A_MCFG1: nxt_rdata = mcfg1_ff;
      `PDT_A_MCFG2: nxt_rdata = mcfg2_ff;
      `PDT_A_MTEMP: nxt_rdata = mtemp_ff;
      `PDT_A_MSUP: nxt_rdata = msup_ff;
      default: nxt_rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) reg_rdata <= nxt_rdata;
    end
  end

  // Checks
  esd_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    esd_mii_evt || esd_mdi_evt |=> isr1_ff[`PDT_ISR1_ESD])
    else $error("discharge event did not raise interrupt flag");
  esd_keep_a: assert property (@(posedge clk) disable iff (por_rst)
    sys_rst && !esd_mii_evt && !esd_mdi_evt |=> $stable(disch_ff))
    else $error("discharge log changed under system reset");
  lq_class_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    link_up && snr_valid && snr_meas <= `PDT_LQ_POOR
    ##1 link_up && !snr_valid |=> lq_cls_ff == 2'h1)
    else $error("poor quality not classed as poor");
  lq_track_a: assert property (@(posedge clk) disable iff (sys_rst)
    snr_valid |=> lq_val_ff == $past(snr_meas) && noise_ff == lq_val_ff)
    else $error("quality value not tracking measurement");
  cr_run_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    cr_state_ff == CR_IDLE && wr_crctl && reg_req.wdata[`PDT_CR_START]
    |=> cr_pulse && cr_stat_ff == 2'h1 ##1 !cr_pulse)
    else $error("reflectometry start did not pulse once");
  mon_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    mon_go && over_temp |=> isr2_ff[`PDT_ISR2_OT] && mon_sample)
    else $error("overtemperature not flagged");
  err_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
    cont_mode && err_hit && err_cnt_ff == 8'hff && !rderr_req
    |=> err_cnt_ff == 8'h00)
    else $error("error counter did not wrap");
  err_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
    rderr_req && !err_hit |=> err_hold_ff == $past(err_cnt_ff)
    && err_cnt_ff == 8'h00)
    else $error("error count not latched and cleared");
  mac_loop_a: assert property (@(posedge clk) disable iff (sys_rst)
    bmctl_ff[`PDT_BMC_LOOP] |-> !link_ind && loop_ctl.mii)
    else $error("link shown during MAC loopback");
  pcs_iso_a: assert property (@(posedge clk) disable iff (sys_rst)
    stctl_ff[6:2] == `PDT_LB_PCS |-> loop_ctl.rx_pma_iso)
    else $error("receive PMA not isolated in PCS loop");
  lock_seen_c: cover property (@(posedge clk) disable iff (sys_rst)
    !lock_ff ##1 lock_ff);
  cr_done_c: cover property (@(posedge clk) disable iff (sys_rst)
    cr_state_ff == CR_LISTEN ##1 cr_stat_ff == 2'h3);
  mon_one_c: cover property (@(posedge clk) disable iff (sys_rst)
    !mcfg2_ff[`PDT_MC2_PER] && mon_go);
endmodule
`default_nettype wire

//--- test/pdt_far_end.sv
// Far-end model: self-test loop partner and cable reflection source
`timescale 1ns/1ns
`default_nettype none
module pdt_far_end import pdt_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Self-test bytes and error injection request
  input wire pdt_byte_s st_tx,
  output var pdt_byte_s st_rx,
  input wire logic [8:0] inj_n,
  input wire logic inj_go,
  // Reflectometry line
  input wire logic cr_pulse,
  output var pdt_refl_s refl
);
  logic [8:0] left_ff;
  logic [5:0] age_ff;
  // Loop bytes back a cycle late; idle data toggles so stale bytes never match
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_rx <= '0;
    end else begin
      st_rx.valid <= st_tx.valid;
      st_rx.data <= st_tx.valid ? st_tx.data ^ {7'h00, left_ff != 9'h000}
                                : ~st_rx.data;
    end
  end
  // Bytes still to corrupt, loaded on request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left_ff <= 9'h000;
    end else if (inj_go) begin
      left_ff <= inj_n;
    end else if (st_tx.valid && left_ff != 9'h000) begin
      left_ff <= left_ff - 9'h001;
    end
  end
  // Echo timer restarted by each pulse; parks at its top value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      age_ff <= 6'h3f;
    end else if (cr_pulse) begin
      age_ff <= 6'h00;
    end else if (age_ff != 6'h3f) begin
      age_ff <= age_ff + 6'h01;
    end
  end
  // Near open fault, far short; fields wander between echoes
  always_comb begin
    refl = {1'b0, age_ff[0], 4'h0, age_ff, age_ff, 2'b11};
    if (age_ff == 6'h05)
      refl = {1'b1, 1'b1, 10'h005, 8'h0a};
    if (age_ff == 6'h0a)
      refl = {1'b1, 1'b0, 10'h00c, 8'h03};
  end
endmodule
`default_nettype wire

//--- test/pdt_diag_tb.sv
// Self-checking bench for the diagnostic tool kit
`timescale 1ns/1ns
`default_nettype none
module pdt_diag_tb import pdt_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic por_rst = 1'b1;
  logic link_up = 1'b0;
  logic snr_valid = 1'b0;
  logic esd_mii_evt = 1'b0;
  logic esd_mdi_evt = 1'b0;
  logic over_temp = 1'b1;
  logic under_volt = 1'b0;
  logic inj_go = 1'b0;
  logic [8:0] inj_n = 9'h000;
  logic [7:0] snr_meas = 8'h00;
  logic [7:0] temp_code = 8'h55;
  logic [7:0] analog_supply_code = 8'h12;
  logic [7:0] io_supply_code = 8'h34;
  pdt_req_s reg_req = '0;
  logic [15:0] reg_rdata;
  logic [15:0] rdv;
  logic reg_rvalid;
  logic cr_pulse;
  logic mon_sample;
  logic link_ind;
  pdt_refl_s refl;
  pdt_byte_s st_tx;
  pdt_byte_s st_rx;
  pdt_loop_s loop_ctl;
  int bad_count = 0;
  int checks_done = 0;
  int n;

  pdt_diag #(.MON_TICK_CYCLES(10)) dut (.clk(clk), .sys_rst(sys_rst),
    .por_rst(por_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .link_up(link_up), .snr_valid(snr_valid),
    .snr_meas(snr_meas), .esd_mii_evt(esd_mii_evt),
    .esd_mdi_evt(esd_mdi_evt), .cr_pulse(cr_pulse), .refl(refl),
    .mon_sample(mon_sample), .temp_code(temp_code), .analog_supply_code(analog_supply_code),
    .io_supply_code(io_supply_code), .over_temp(over_temp),
    .under_volt(under_volt), .st_tx(st_tx), .st_rx(st_rx),
    .loop_ctl(loop_ctl), .link_ind(link_ind));
  pdt_far_end far (.clk(clk), .sys_rst(sys_rst), .st_tx(st_tx),
    .st_rx(st_rx), .inj_n(inj_n), .inj_go(inj_go), .cr_pulse(cr_pulse),
    .refl(refl));

  // Compare, count, report at once
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      bad_count++;
    end
  endtask
  // A wait that ran out ends the run
  task automatic tmo(input logic ok, input string nm);
    if (ok !== 1'b1) begin
      $display("[FAIL] %s exp 1 got 0", nm);
      bad_count++;
      results();
    end
  endtask
  // Register write: strobe one cycle, effective at the taking edge
  task automatic wr(input logic [15:0] a, d);
    @(posedge clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask
  // Register read: data and valid one cycle after the strobe
  task automatic rdc(input logic [15:0] a, e, input string nm);
    @(posedge clk);
    reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    rdv = reg_rdata;
    chk("rvalid", 16'h0001, {15'h0000, reg_rvalid});
    chk(nm, e, rdv);
  endtask

  task automatic t_reset();
    rdc(16'h0480, 16'h0001, "monitor_config_one");
    rdc(16'h0481, 16'h0002, "monitor_config_two");
    rdc(16'h001c, 16'h0040, "pkt_len");
    rdc(16'h001b, 16'h000c, "gap_len");
    wr(16'h0100, 16'hffff);
    rdc(16'h0100, 16'h0000, "unmapped");
  endtask
  // Class boundaries around 40 and 70, then link lost
  task automatic t_quality();
    logic [7:0] v[5] = '{8'h28, 8'h29, 8'h46, 8'h47, 8'h50};
    logic [1:0] c[5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      link_up <= (i < 4);
      snr_valid <= 1'b1;
      snr_meas <= v[i];
      @(posedge clk);
      snr_valid <= 1'b0;
      repeat (2) @(posedge clk);
      rdc(16'h0197, {8'h00, v[i]}, "noise");
      rdc(16'h0198, {6'h00, c[i], v[i]}, "quality");
    end
  endtask
  // Two MAC-side and one line-side event; log survives reset
  task automatic t_discharge();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      esd_mii_evt <= (i != 1);
      esd_mdi_evt <= (i == 1);
      @(posedge clk);
      esd_mii_evt <= 1'b0;
      esd_mdi_evt <= 1'b0;
    end
    rdc(16'h0448, 16'h0102, "discharge");
    rdc(16'h0012, 16'h0800, "isr1");
    rdc(16'h0012, 16'h0000, "isr1 clr");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(16'h0448, 16'h0102, "kept log");
  endtask
  // One run, two echoes, status after the listen window
  task automatic t_reflect();
    wr(16'h001e, 16'h8000);
    chk("pulse", 16'h0001, {15'h0000, cr_pulse});
    rdc(16'h001e, 16'h0001, "busy");
    repeat (55) @(posedge clk);
    rdc(16'h001e, 16'h0003, "done");
    rdc(16'h016b, 16'ha805, "peak one");
    rdc(16'h0180, 16'h0c0c, "peak two");
    rdc(16'h018a, 16'h0001, "peak kind");
  endtask
  // Cycles between two monitor runs
  task automatic t_period(input logic [15:0] e);
    for (n = 0; n < 3000 && !mon_sample; n++) @(posedge clk) #1;
    tmo(mon_sample, "first run");
    @(posedge clk) #1;
    for (n = 1; n < 3000 && !mon_sample; n++) @(posedge clk) #1;
    chk("period", e, n[15:0]);
  endtask
  task automatic t_monitor();
    t_period(16'd310);
    rdc(16'h0013, 16'h0002, "isr2 hot");
    rdc(16'h0484, 16'h0155, "temp stat");
    rdc(16'h0485, 16'h3412, "supply");
    wr(16'h0480, 16'h0000);
    t_period(16'd160);
    wr(16'h0480, 16'h0007);
    t_period(16'd2400);
    rdc(16'h0013, 16'h0002, "isr2 hot");
    wr(16'h0481, 16'h0000);
    @(posedge clk);
    over_temp <= 1'b0;
    under_volt <= 1'b1;
    temp_code <= 8'h22;
    wr(16'h0481, 16'h0001);
    for (n = 0; n < 5 && !mon_sample; n++) @(posedge clk) #1;
    tmo(mon_sample, "single run");
    rdc(16'h0013, 16'h0001, "isr2 low");
    rdc(16'h0484, 16'h0022, "temp stat");
  endtask
  // Every loop select code, then MAC loop hiding link
  task automatic t_loop();
    logic [4:0] s[3] = '{5'h01, 5'h02, 5'h04};
    logic [5:0] e[3] = '{6'h12, 6'h08, 6'h05};
    for (int i = 0; i < 3; i++) begin
      wr(16'h0016, {9'h000, s[i], 2'b00});
      chk("loop", {10'h000, e[i]}, {10'h000, loop_ctl});
    end
    wr(16'h0016, 16'h0000);
    @(posedge clk);
    link_up <= 1'b1;
    wr(16'h0000, 16'h4000);
    chk("mii loop", 16'h0020, {10'h000, loop_ctl});
    chk("link hide", 16'h0000, {15'h0000, link_ind});
    wr(16'h0000, 16'h0000);
    chk("link show", 16'h0001, {15'h0000, link_ind});
  endtask
  // Inject bytes in error, let them pass, latch the count
  task automatic t_inject(input logic [8:0] k, input int w);
    @(posedge clk);
    inj_n <= k;
    inj_go <= 1'b1;
    @(posedge clk);
    inj_go <= 1'b0;
    repeat (w) @(posedge clk);
    wr(16'h001b, 16'h8004);
  endtask
  task automatic t_selftest();
    wr(16'h001c, 16'h0008);
    wr(16'h001b, 16'h0004);
    wr(16'h0016, 16'h2004);
    for (n = 0; n < 100 && st_tx.valid; n++) @(posedge clk) #1;
    for (n = 0; n < 100 && !st_tx.valid; n++) @(posedge clk) #1;
    tmo(st_tx.valid, "first byte");
    for (n = 0; n < 100 && st_tx.valid; n++) @(posedge clk) #1;
    chk("pkt bytes", 16'h0008, n[15:0]);
    for (n = 0; n < 100 && !st_tx.valid; n++) @(posedge clk) #1;
    chk("gap cycles", 16'h0004, n[15:0]);
    rdc(16'h0016, 16'h2604, "lock sync");
    chk("lock", 16'h0001, {15'h0000, rdv[10]});
    wr(16'h001b, 16'h8004);
    t_inject(9'h003, 40);
    rdc(16'h001b, 16'h0304, "errors");
    wr(16'h001b, 16'h8004);
    rdc(16'h001b, 16'h0004, "cleared");
    wr(16'h0016, 16'h6004);
    wr(16'h001b, 16'h8004);
    t_inject(9'h102, 450);
    rdc(16'h001b, 16'h0204, "wrapped");
  endtask

  // Counts, then verdict, then stop
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    t_reset();
    t_quality();
    t_discharge();
    t_reflect();
    t_monitor();
    t_loop();
    t_selftest();
    results();
  end
endmodule
`default_nettype wire
